/* File: logic/audio_out_fmt.v */
// serial audio output formatter with AXI4-Lite control
// assumes aclk at 200 MHz; bit and frame clock pins are two-way, and
// in slave mode they come from another clock domain
`timescale 1ns/1ps
`default_nettype none
`include "audio_out_map.vh"

module audio_out_fmt (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bit_clk_i,
  output reg         bit_clk_o,
  output wire        bit_clk_oe_n,
  input  wire        frame_clk_i,
  output reg         frame_clk_o,
  output wire        frame_clk_oe_n,
  output reg         serial_out_lane0,
  output reg         serial_out_lane1,
  output reg         serial_out_lane2,
  output reg         serial_out_lane3
);

  // ---------------- register file ----------------
  reg [`CTRL_W-1:0] ctrl_r;
  reg               underrun_r;
  reg [15:0]        aw_addr_r;
  reg               aw_held_r;
  reg [31:0]        w_data_r;
  reg [3:0]         w_strb_r;
  reg               w_held_r;

  wire [1:0] out_sample_length    = ctrl_r[`F_LEN_HI:`F_LEN_LO];
  wire [2:0] msb_pos              = ctrl_r[`F_MSB_HI:`F_MSB_LO];
  wire       tdm_en               = ctrl_r[`F_TDM];
  wire       frame_sync_shape     = ctrl_r[`F_FSYNC];
  wire [1:0] frame_clock_rate_sel = ctrl_r[`F_RATE_HI:`F_RATE_LO];
  wire       master               = ctrl_r[`F_MASTER];

  wire        fifo_in_ready;
  wire [23:0] fifo_out_data;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [3:0]  fifo_level;

  wire wr_is_ctrl   = (aw_addr_r == `CTRL_ADDR);
  wire wr_is_data   = (aw_addr_r == `DATA_ADDR);
  wire wr_is_status = (aw_addr_r == `STATUS_ADDR);
  // a data write waits here while the FIFO is full
  wire wr_go   = aw_held_r && w_held_r && !s_axi_bvalid &&
                 (!wr_is_data || fifo_in_ready);
  wire push    = wr_go && wr_is_data;
  wire clr_und = wr_go && wr_is_status && w_strb_r[0] &&
                 w_data_r[`S_UNDERRUN];
  wire set_und;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 16'h0000;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_r       <= `CTRL_RESET;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_is_ctrl || wr_is_data || wr_is_status) ?
                        2'h0 : 2'h2;
        if (wr_is_ctrl && w_strb_r[0])
          ctrl_r[7:0] <= w_data_r[7:0];
        if (wr_is_ctrl && w_strb_r[1])
          ctrl_r[`CTRL_W-1:8] <= w_data_r[`CTRL_W-1:8];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `CTRL_ADDR:
          s_axi_rdata <= {18'h00000, ctrl_r};
        `STATUS_ADDR:
          s_axi_rdata <= {20'h00000, fifo_level, 7'h00, underrun_r};
        `DATA_ADDR:
          s_axi_rdata <= 32'h00000000;
        default:
          s_axi_rresp <= 2'h2;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // underrun: set wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn)
      underrun_r <= 1'b0;
    else if (set_und)
      underrun_r <= 1'b1;
    else if (clr_und)
      underrun_r <= 1'b0;
  end

  sample_fifo #(
    .WIDTH (`SAMPLE_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (w_data_r[23:0]),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .level     (fifo_level)
  );

  // ---------------- frame buffers ----------------
  // samples for the next frame are gathered while the current one plays
  reg [23:0] next_buf_r [0:7];
  reg [23:0] cur_buf_r  [0:7];
  reg [3:0]  fill_r;
  wire       frame_start;

  assign fifo_out_ready = (fill_r != 4'h8) && !frame_start;
  assign set_und        = frame_start && (fill_r != 4'h8);

  always @(posedge aclk) begin
    if (!aresetn)
      fill_r <= 4'h0;
    else if (frame_start && fill_r == 4'h8)
      fill_r <= 4'h0;
    else if (fifo_out_valid && fifo_out_ready)
      fill_r <= fill_r + 4'h1;
  end

  // a short frame plays silence rather than stale samples
  genvar gi;
  generate
    for (gi = 0; gi < `CHANNELS; gi = gi + 1) begin : g_buf
      always @(posedge aclk) begin
        if (!aresetn) begin
          next_buf_r[gi] <= 24'h000000;
          cur_buf_r[gi]  <= 24'h000000;
        end else begin
          if (fifo_out_valid && fifo_out_ready && fill_r == gi)
            next_buf_r[gi] <= fifo_out_data;
          if (frame_start)
            cur_buf_r[gi] <= (fill_r == 4'h8) ? next_buf_r[gi] :
                             24'h000000;
        end
      end
    end
  endgenerate

  // ---------------- bit timing ----------------
  // only master uses the rate; one internal tick is INT_DIV aclks
  wire [1:0] rate_eff = (frame_clock_rate_sel == 2'h3) ? 2'h2 :
                        frame_clock_rate_sel;
  // ticks per frame 1024 >> rate over 64 or 256 bits per frame
  wire [2:0] shift    = (tdm_en ? 3'd2 : 3'd4) - {1'b0, rate_eff};
  wire [6:0] period   = `INT_DIV << shift;
  wire [6:0] half     = {1'b0, period[6:1]};

  reg  [6:0] cyc_r;
  reg        bclk_s1_r;
  reg        bclk_s2_r;
  reg        bclk_s3_r;
  reg        lr_s1_r;
  reg        lr_s2_r;
  reg        lr_last_r;
  reg  [7:0] bcnt_r;
  reg        step_d_r;

  wire m_step = master && (cyc_r >= period - 7'd1);
  // slave steps on the falling edge of the bit clock it is given
  wire s_step = !master && bclk_s3_r && !bclk_s2_r;
  wire step   = m_step || s_step;
  wire [7:0] last_bit = tdm_en ? 8'hFF : 8'h3F;
  wire s_frame = frame_sync_shape ? (lr_s2_r && !lr_last_r) :
                                    (!lr_s2_r && lr_last_r);
  wire wrap    = master ? (bcnt_r >= last_bit) : s_frame;

  assign frame_start = step && wrap;

  always @(posedge aclk) begin
    if (!aresetn) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      lr_s1_r   <= 1'b0;
      lr_s2_r   <= 1'b0;
    end else begin
      bclk_s1_r <= bit_clk_i;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      lr_s1_r   <= frame_clk_i;
      lr_s2_r   <= lr_s1_r;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r     <= 7'h00;
      bcnt_r    <= 8'h00;
      lr_last_r <= 1'b0;
      step_d_r  <= 1'b0;
    end else begin
      step_d_r <= step;
      if (step || !master)
        cyc_r <= 7'h00;
      else
        cyc_r <= cyc_r + 7'h01;
      if (step) begin
        lr_last_r <= lr_s2_r;
        bcnt_r    <= wrap ? 8'h00 : bcnt_r + 8'h01;
      end
    end
  end

  // ---------------- serial formatting ----------------
  function [4:0] msb_delay;
    input [2:0] code;
    begin
      case (code)
        3'h0:    msb_delay = 5'd1;
        3'h1:    msb_delay = 5'd0;
        3'h2:    msb_delay = 5'd8;
        3'h3:    msb_delay = 5'd12;
        3'h4:    msb_delay = 5'd16;
        default: msb_delay = 5'd1;
      endcase
    end
  endfunction

  function [4:0] word_len;
    input [1:0] code;
    begin
      case (code)
        2'h0:    word_len = 5'd24;
        2'h1:    word_len = 5'd20;
        2'h2:    word_len = 5'd16;
        default: word_len = 5'd24;
      endcase
    end
  endfunction

  // bit of a sample at slot position pos; zero before MSB and after LSB
  function slot_bit;
    input [23:0] smp;
    input [4:0]  pos;
    input [4:0]  dly;
    input [4:0]  len;
    reg   [5:0]  d;
    begin
      d = {1'b0, pos} - {1'b0, dly};
      if (pos < dly || d >= {1'b0, len})
        slot_bit = 1'b0;
      else
        slot_bit = smp[5'd23 - d[4:0]];
    end
  endfunction

  wire [4:0] pos  = bcnt_r[4:0];
  wire [4:0] dly  = msb_delay(msb_pos);
  wire [4:0] len  = word_len(out_sample_length);
  wire [2:0] tslt = bcnt_r[7:5];
  wire       half_sel = bcnt_r[5];
  // second half of the frame is high in word-clock mode
  wire lr_next = frame_sync_shape ? (bcnt_r == 8'h00) :
                 (tdm_en ? bcnt_r[7] : bcnt_r[5]);

  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_lane0 <= 1'b0;
      serial_out_lane1 <= 1'b0;
      serial_out_lane2 <= 1'b0;
      serial_out_lane3 <= 1'b0;
      frame_clk_o      <= 1'b0;
      bit_clk_o        <= 1'b0;
    end else begin
      bit_clk_o <= master && (cyc_r >= half);
      if (step_d_r) begin
        frame_clk_o <= lr_next;
        if (tdm_en) begin
          serial_out_lane0 <= slot_bit(cur_buf_r[tslt], pos, dly, len);
          serial_out_lane1 <= 1'b0;
          serial_out_lane2 <= 1'b0;
          serial_out_lane3 <= 1'b0;
        end else begin
          serial_out_lane0 <= slot_bit(cur_buf_r[{2'h0, half_sel}],
                                       pos, dly, len);
          serial_out_lane1 <= slot_bit(cur_buf_r[{2'h1, half_sel}],
                                       pos, dly, len);
          serial_out_lane2 <= slot_bit(cur_buf_r[{2'h2, half_sel}],
                                       pos, dly, len);
          serial_out_lane3 <= slot_bit(cur_buf_r[{2'h3, half_sel}],
                                       pos, dly, len);
        end
      end
    end
  end

  // clock pins are driven only in master mode
  assign bit_clk_oe_n   = !master;
  assign frame_clk_oe_n = !master;

endmodule // audio_out_fmt

`default_nettype wire

/* File: logic/audio_out_map.vh */
// register map, field positions, reset values and timing of the
// serial audio output formatter; included by audio_out_fmt.v, the checker and the bench
`ifndef AUDIO_OUT_MAP_VH
`define AUDIO_OUT_MAP_VH

// register index of the control word; byte address is four times it
`define CTRL_INDEX        16'd2078
`define CTRL_ADDR         16'h2078
`define DATA_ADDR         16'h2080
`define STATUS_ADDR       16'h2084
`define ADDR_W            16

// control word fields
`define CTRL_RESET        14'h0000
`define CTRL_W            14
`define F_LEN_LO          0
`define F_LEN_HI          1
`define F_MSB_LO          2
`define F_MSB_HI          4
`define F_TDM             5
`define F_FSYNC           6
`define F_RATE_LO         7
`define F_RATE_HI         8
`define F_MASTER          11

// status word fields
`define S_UNDERRUN        0
`define S_FILL_LO         8
`define S_FILL_HI         11

// sample and frame geometry
`define SAMPLE_W          24
`define SLOT_BITS         32
`define CHANNELS          8
`define FIFO_DEPTH        8

// internal clock: 1024 x fs at rate 0, made from aclk by an enable divider
`define ACLK_PERIOD_PS    5000
`define INT_PERIOD_PS     20000
// aclks per internal tick: INT_PERIOD_PS over ACLK_PERIOD_PS
`define INT_DIV           7'd4

`endif

/* File: logic/sample_fifo.v */
// synchronous FIFO of flip-flops, width and depth by parameter
// assumes one clock, sync active-low reset; depth a power of two
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wr_ptr_r;
  reg [AW:0]      rd_ptr_r;

  wire push;
  wire pop;

  // extra pointer bit tells full from empty
  assign level     = wr_ptr_r - rd_ptr_r;
  // depth is 2**AW, so the top level bit alone marks full
  assign in_ready  = !level[AW];
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // storage needs no reset: nothing is read before it is written
  always @(posedge aclk) begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

endmodule // sample_fifo

`default_nettype wire

/* File: sim/audio_rx_model.sv */
// receiver model: shifts in one lane on the rising bit clock
// assumes data change on the falling bit clock, MSB of frame first
`timescale 1ns/1ps
`default_nettype none

module audio_rx_model (
  input  wire logic         bclk,
  input  wire logic         fclk,
  input  wire logic         sdata,
  input  wire logic         shape,
  output var  logic [255:0] frame_q,
  output var  int           frames
);
  logic [255:0] sh_r = 256'h0;
  logic         fp_r = 1'b0;
  // word clock falls, pulse rises, at the first bit of a frame
  wire          start = shape ? (fclk & ~fp_r) : (~fclk & fp_r);

  initial frames = 0;
  always @(posedge bclk) begin
    fp_r <= fclk;
    if (start) begin
      frame_q <= sh_r;
      frames <= frames + 1;
    end
    sh_r <= start ? {255'h0, sdata} : {sh_r[254:0], sdata};
  end
endmodule // audio_rx_model
`default_nettype wire

/* File: sim/audio_out_fmt_props.sv */
// checker: clock rates, frame sync shape, lane use, pin direction
// assumes only the formatter ports; control word mirrored off AXI
`timescale 1ns/1ps
`default_nettype none
`include "audio_out_map.vh"

module audio_out_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        bit_clk_o,
  input wire logic        bit_clk_oe_n,
  input wire logic        frame_clk_o,
  input wire logic        frame_clk_oe_n,
  input wire logic        serial_out_lane1,
  input wire logic        serial_out_lane2,
  input wire logic        serial_out_lane3
);
  logic [15:0] wa_r;
  logic [11:0] wd_r, ctl_r;
  logic [12:0] fcnt_r, fhi_r, bhi_r;
  logic [1:0]  seen_r;
  logic        fq_r, bq_r;
  wire  [1:0]  rt = (ctl_r[8:7] == 2'h3) ? 2'h2 : ctl_r[8:7];
  wire  [12:0] fper = 13'h1000 >> rt;
  wire  [12:0] bper = 13'h4 << ((ctl_r[5] ? 3'h2 : 3'h4) - rt);
  wire         frise = frame_clk_o & ~fq_r;
  wire         ffall = ~frame_clk_o & fq_r;
  // first frames after a change may be partial, so skip three
  wire         ok = (seen_r == 2'h3) & ctl_r[11];
  wire         idle = ~s_axi_awvalid & ~s_axi_wvalid & ~s_axi_bvalid;

  always @(posedge aclk) begin
    fq_r <= frame_clk_o;
    bq_r <= bit_clk_o;
    fcnt_r <= frise ? 13'h1 : fcnt_r + 13'h1;
    fhi_r <= frise ? 13'h1 : fhi_r + {12'h0, frame_clk_o};
    bhi_r <= (bit_clk_o & ~bq_r) ? 13'h1 : bhi_r + {12'h0, bit_clk_o};
    if (s_axi_awvalid & s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_wvalid & s_axi_wready) wd_r <= s_axi_wdata[11:0];
    if (frise & (seen_r != 2'h3)) seen_r <= seen_r + 2'h1;
    if (s_axi_bvalid & s_axi_bready & (wa_r == `CTRL_ADDR)) begin
      ctl_r <= wd_r;
      seen_r <= 2'h0;
    end
    if (!aresetn) begin
      ctl_r <= 12'h0;
      seen_r <= 2'h0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  frame_rate_a:
    assert property (frise && ok |-> fcnt_r == fper) else $error("fclk period");
  bit_rate_a:
    assert property (!bit_clk_o && bq_r && ok |-> bhi_r == bper >> 1)
    else $error("bclk period");
  word_duty_a:
    assert property (ffall && ok && !ctl_r[6] |-> fhi_r == fper >> 1)
    else $error("word clock duty");
  sync_pulse_a:
    assert property (ffall && ok && ctl_r[6] |-> fhi_r == bper)
    else $error("sync pulse width");
  tdm_lanes_a:
    assert property (ok && ctl_r[5] |-> !(serial_out_lane1 ||
      serial_out_lane2 || serial_out_lane3)) else $error("lane busy in tdm");
  slave_bclk_a:
    assert property (idle && !ctl_r[11] |-> bit_clk_oe_n)
    else $error("bclk driven as slave");
  slave_fclk_a:
    assert property (idle && !ctl_r[11] |-> frame_clk_oe_n)
    else $error("fclk driven as slave");
  master_pins_a:
    assert property (idle && ctl_r[11] |-> !bit_clk_oe_n && !frame_clk_oe_n)
    else $error("pins not driven as master");

  cover property (frise && ok && ctl_r[5]);
  cover property (ffall && ok && ctl_r[6]);
  cover property (frise && ok && !ctl_r[5]);
endmodule // audio_out_props

bind audio_out_fmt audio_out_props i_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .bit_clk_o, .bit_clk_oe_n,
  .frame_clk_o, .frame_clk_oe_n, .serial_out_lane1, .serial_out_lane2,
  .serial_out_lane3);
`default_nettype wire

/* File: sim/serial_audio_output_format_tb.sv */
// bench: configures the formatter as master and slave over AXI4-Lite, checks
// the slots of all four lanes through the receiver models; pins idle low outside
`timescale 1ns/1ps
`default_nettype none
`include "audio_out_map.vh"

module serial_audio_output_format_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, bit_clk_o, bit_clk_oe_n, frame_clk_o;
  logic frame_clk_oe_n, serial_out_lane0, serial_out_lane1;
  logic serial_out_lane2, serial_out_lane3, bit_clk_i, frame_clk_i;
  logic [255:0] rx_frame, rx_f1, rx_f2, rx_f3;
  logic [31:0] ctl;
  logic [9:0] sl_cnt = 10'h0;
  logic sl_go = 1'b0;
  logic [8:0] cfg = 9'h0;
  // last entry runs as slave on bench clocks; its rate must not matter
  logic [8:0] cfgs [7] = '{9'h180, 9'h1A5, 9'h14A, 9'h12C, 9'h191, 9'h0A2,
                           9'h040};
  int rx_cnt, err_total = 0, tests_run = 0;

  always #2.5 aclk = ~aclk;
  // slave clocks: 16 aclk bits, 64-bit frames, frame edge on bit fall
  always @(posedge aclk) sl_cnt <= sl_go ? sl_cnt + 10'h1 : 10'h0;
  assign bit_clk_i = bit_clk_oe_n ? sl_cnt[3] : bit_clk_o;
  assign frame_clk_i = frame_clk_oe_n ? sl_cnt[9] : frame_clk_o;

  audio_out_fmt i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_clk_i, .bit_clk_o,
    .bit_clk_oe_n, .frame_clk_i, .frame_clk_o, .frame_clk_oe_n,
    .serial_out_lane0, .serial_out_lane1, .serial_out_lane2,
    .serial_out_lane3);
  audio_rx_model i_rx (.bclk(bit_clk_i), .fclk(frame_clk_i),
    .sdata(serial_out_lane0), .shape(cfg[5]), .frame_q(rx_frame),
    .frames(rx_cnt));
  audio_rx_model i_rx1 (.bclk(bit_clk_i), .fclk(frame_clk_i),
    .sdata(serial_out_lane1), .shape(cfg[5]), .frame_q(rx_f1), .frames());
  audio_rx_model i_rx2 (.bclk(bit_clk_i), .fclk(frame_clk_i),
    .sdata(serial_out_lane2), .shape(cfg[5]), .frame_q(rx_f2), .frames());
  audio_rx_model i_rx3 (.bclk(bit_clk_i), .fclk(frame_clk_i),
    .sdata(serial_out_lane3), .shape(cfg[5]), .frame_q(rx_f3), .frames());
  wire [767:0] rx_hi = {rx_f3, rx_f2, rx_f1};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_frames(input int n);
    int f;
    f = rx_cnt;
    wait (rx_cnt == f + n);
  endtask

  function automatic logic [23:0] smp(input int k);
    return 24'hC35A1D + 24'h011111 * k[23:0];
  endfunction

  // c is {delay code, length code}; slot is 32 bits, tail zero filled
  function automatic logic [31:0] slot_exp(input logic [23:0] s,
                                           input logic [4:0] c);
    logic [31:0] w;
    w = {s, 8'h00} & ~(32'hFFFFFFFF >> (c[1] ? 16 : c[0] ? 20 : 24));
    return w >> ((c[4:2] == 3'h0) ? 1 : (c[4:2] == 3'h1) ? 0 : 4 * c[4:2]);
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CTRL_ADDR);
    chk(rdat, 32'h0);
    chk({31'h0, bit_clk_oe_n}, 32'h1);
    rd(16'h0FF0);
    chk({30'h0, resp}, 32'h2);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      cfg = cfgs[i];
      ctl = {20'h0, (i != 6), 2'h0, cfg[7:6], cfg[5], cfg[8], cfg[4:0]};
      wr(`CTRL_ADDR, ctl);
      chk({30'h0, resp}, 32'h0);
      @(posedge aclk);
      sl_go <= (i == 6);
      chk({30'h0, bit_clk_oe_n, frame_clk_oe_n},
          (i == 6) ? 32'h3 : 32'h0);
      rd(`CTRL_ADDR);
      chk(rdat, ctl);
      wait_frames(2);
      for (int k = 0; k < 8; k++) wr(`DATA_ADDR, {8'h0, smp(k)});
      // samples queued early in a frame play in the next one
      wait_frames(2);
      for (int k = 0; k < (cfg[8] ? 8 : 2); k++)
        chk(rx_frame[(cfg[8] ? 255 : 63) - 32 * k -: 32],
            slot_exp(smp(k), cfg[4:0]));
      // lanes 1 to 3: channels 2 to 7 in stereo, silent in TDM
      for (int j = 0; j < 6; j++)
        if (cfg[8]) chk({31'h0, |rx_hi[256 * (j / 2) +: 256]}, 32'h0);
        else chk(rx_hi[256 * (j / 2) + 63 - 32 * (j % 2) -: 32],
                 slot_exp(smp(j + 2), cfg[4:0]));
      $display("test cfg %0d done", i);
    end
    sl_go <= 1'b0;
    wr(`CTRL_ADDR, 32'h0);
    @(posedge aclk);
    chk({31'h0, bit_clk_oe_n}, 32'h1);
    // short frames have played, so underrun is set and the FIFO empty
    rd(`STATUS_ADDR);
    chk(rdat, 32'h1);
    wr(`STATUS_ADDR, 32'h1);
    chk({30'h0, resp}, 32'h0);
    rd(`STATUS_ADDR);
    chk(rdat, 32'h0);
    $display("test release done");
    test_done;
  end

  initial begin
    repeat (90000) @(posedge aclk);
    err_total++;
    test_done;
  end
endmodule // serial_audio_output_format_tb
`default_nettype wire
